// file: shared/tx_rx_pkg.sv
package tx_rx_pkg;
    // Register byte addresses on the APB slave.
    localparam logic [7:0] CTRL_ADDR_TX_STATUS = 8'h04;
    localparam logic [7:0] CTRL_ADDR_RX_CFG = 8'h0C;
    localparam logic [7:0] CTRL_ADDR_STATION_LO = 8'h10;
    localparam logic [7:0] CTRL_ADDR_STATION_HI = 8'h14;
    localparam logic [7:0] CTRL_ADDR_HASH_LO = 8'h18;
    localparam logic [7:0] CTRL_ADDR_HASH_HI = 8'h1C;
    localparam logic [7:0] CTRL_ADDR_COLL_COUNT = 8'h20;
    localparam logic [7:0] CTRL_ADDR_IRQ_STATUS = 8'h24;
    localparam logic [7:0] CTRL_ADDR_IRQ_MASK = 8'h28;

    // Transmit status field positions.
    localparam int TS_SENT = 0;
    localparam int TS_COLL = 2;
    localparam int TS_ABORT = 3;
    localparam int TS_CARRIER_LOST = 4;
    localparam int TS_UNDERRUN = 5;
    localparam int TS_HB = 6;
    localparam int TS_LATE = 7;

    // Receive configuration field positions.
    localparam int RC_KEEP_ERR = 0;
    localparam int RC_SHORT = 1;
    localparam int RC_BCAST = 2;
    localparam int RC_HASH = 3;
    localparam int RC_PROMISC = 4;

    // Interrupt status and mask field positions.
    localparam int IRQ_TX_END = 0;
    localparam int IRQ_RX_DONE = 1;

    // Reset values.
    localparam logic [7:0] TX_STATUS_RST = 8'h00;
    localparam logic [7:0] RX_CFG_RST = 8'h00;
    localparam logic [1:0] IRQ_RST = 2'h0;

    // Timing in nanoseconds and derived cycle counts at the system clock.
    localparam int CLK_MHZ = 50;
    localparam int HB_WINDOW_NS = 6400;
    localparam int SLOT_NS = 51200;
    localparam int HB_CYCLES = HB_WINDOW_NS * CLK_MHZ / 1000;
    localparam int SLOT_CYCLES = (SLOT_NS * CLK_MHZ + 999) / 1000;

    // Frame limits and retry limit.
    localparam int MAX_ATTEMPTS = 16;
    localparam int MIN_FRAME = 64;
    localparam int MIN_RUNT = 8;

    // A finished received frame as seen by the address filter.
    typedef struct packed {
        logic [47:0] dest;
        logic [15:0] len;
        logic crc_err;
        logic [5:0] hash_idx;
    } rx_frame_t;
endpackage

// file: logic/tx_status_rx_filter_config.sv
`timescale 1ns/1ps
module tx_status_rx_filter_config
    import tx_rx_pkg::*;
(
    // Clock, reset and clock enable.
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // APB slave.
    input wire logic [7:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Transmit engine events, same clock.
    input wire logic tx_start_i,
    input wire logic tx_done_i,
    input wire logic collision_i,
    input wire logic fifo_empty_i,
    input wire logic bus_grant_i,
    // Transceiver pins, asynchronous.
    input wire logic carrier_i,
    input wire logic heartbeat_i,
    // Transmit control back to the engine.
    output logic tx_retry_o,
    output logic tx_abort_o,
    // Receive filter.
    input wire logic rx_valid_i,
    input wire rx_frame_t rx_frame_i,
    output logic rx_valid_o,
    output logic rx_accept_o,
    // Interrupt.
    output logic irq_o
);
    localparam int HB_LAST = HB_CYCLES - 1;
    localparam int SLOT_LAST = SLOT_CYCLES - 1;

    logic [7:0] tx_status;
    logic [7:0] rx_cfg;
    logic [47:0] station_address_bytes;
    logic [63:0] hash_bits;
    logic [4:0] collision_count_reg;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic tx_active;
    logic [11:0] slot_cnt;
    logic hb_wait;
    logic [8:0] hb_cnt;
    logic carrier_meta;
    logic carrier_sync;
    logic carrier_prev;
    logic hb_meta;
    logic hb_sync;
    logic apb_access;
    logic wr_fire;
    logic slot_done;
    logic coll_now;
    logic last_attempt;
    logic underrun_now;
    logic done_now;
    logic tx_end_evt;
    logic [31:0] next_rdata;
    logic next_err;
    logic [31:0] wr_data;

    // Transceiver pins pass two flip-flops before any logic reads them.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
        begin
            carrier_meta <= 1'b0;
            carrier_sync <= 1'b0;
            hb_meta <= 1'b0;
            hb_sync <= 1'b0;
        end
        else if (ce_i)
        begin
            carrier_meta <= carrier_i;
            carrier_sync <= carrier_meta;
            hb_meta <= heartbeat_i;
            hb_sync <= hb_meta;
        end
    end

    // Qualified transmit events; a new start overrides anything in flight.
    assign slot_done = (slot_cnt == 12'(SLOT_LAST));
    assign coll_now = tx_active && collision_i && !tx_start_i;
    assign last_attempt = (collision_count_reg == 5'(MAX_ATTEMPTS - 1));
    assign underrun_now = tx_active && fifo_empty_i && !bus_grant_i && !tx_start_i;
    assign done_now = tx_active && tx_done_i && !tx_start_i && !coll_now && !underrun_now;
    assign tx_end_evt = done_now || underrun_now || (coll_now && last_attempt);

    // Transmission in progress and slot timer, restarted at each attempt.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
        begin
            tx_active <= 1'b0;
            slot_cnt <= 12'h000;
        end
        else if (ce_i)
        begin
            if (tx_start_i || coll_now)
                slot_cnt <= 12'h000;
            else if (tx_active && !slot_done)
                slot_cnt <= slot_cnt + 12'h001;
            if (tx_start_i)
                tx_active <= 1'b1;
            else if (tx_end_evt)
                tx_active <= 1'b0;
        end
    end

    // Collision total for the current packet.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
            collision_count_reg <= 5'h00;
        else if (ce_i)
        begin
            if (tx_start_i)
                collision_count_reg <= 5'h00;
            else if (coll_now)
                collision_count_reg <= collision_count_reg + 5'h01;
        end
    end

    // Heartbeat window opens when a transmission completes.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
        begin
            hb_wait <= 1'b0;
            hb_cnt <= 9'h000;
        end
        else if (ce_i)
        begin
            if (tx_start_i || hb_sync || hb_cnt == 9'(HB_LAST))
                hb_wait <= 1'b0;
            else if (done_now)
                hb_wait <= 1'b1;
            if (done_now || !hb_wait)
                hb_cnt <= 9'h000;
            else
                hb_cnt <= hb_cnt + 9'h001;
        end
    end

    // Transmit status; cleared at start and not meaningful before the first one.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
        begin
            tx_status <= TX_STATUS_RST;
            carrier_prev <= 1'b0;
        end
        else if (ce_i)
        begin
            carrier_prev <= carrier_sync;
            if (tx_start_i)
                tx_status <= TX_STATUS_RST;
            else
            begin
                if (coll_now)
                    tx_status[TS_COLL] <= 1'b1;
                if (coll_now && slot_done)
                    tx_status[TS_LATE] <= 1'b1;
                if (coll_now && last_attempt)
                    tx_status[TS_ABORT] <= 1'b1;
                if (tx_active && carrier_prev && !carrier_sync)
                    tx_status[TS_CARRIER_LOST] <= 1'b1;
                if (underrun_now)
                    tx_status[TS_UNDERRUN] <= 1'b1;
                if (done_now)
                    tx_status[TS_SENT] <= 1'b1;
                if (hb_wait && !hb_sync && hb_cnt == 9'(HB_LAST))
                    tx_status[TS_HB] <= 1'b1;
            end
        end
    end

    // Retry and abort strobes to the transmit engine.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
        begin
            tx_retry_o <= 1'b0;
            tx_abort_o <= 1'b0;
        end
        else if (ce_i)
        begin
            tx_retry_o <= coll_now && !last_attempt;
            tx_abort_o <= underrun_now || (coll_now && last_attempt);
        end
    end

    // Address filter decision on each finished frame.
    function automatic logic frame_ok(input rx_frame_t f, input logic [7:0] cfg,
                                      input logic [47:0] sta, input logic [63:0] hash);
        logic err_ok;
        logic len_ok;
        logic bcast;
        logic addr_ok;
        err_ok = !f.crc_err || cfg[RC_KEEP_ERR];
        len_ok = (f.len >= 16'(MIN_FRAME))
            || (cfg[RC_SHORT] && f.len >= 16'(MIN_RUNT));
        bcast = &f.dest;
        if (bcast)
            addr_ok = cfg[RC_BCAST];
        else if (f.dest[0])
            addr_ok = cfg[RC_HASH] && hash[f.hash_idx];
        else
            addr_ok = cfg[RC_PROMISC] || (f.dest == sta);
        // Each destination class is judged on its own, so enabled classes add up.
        return err_ok && len_ok && addr_ok;
    endfunction

    // Filter outputs, one result per frame.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
        begin
            rx_valid_o <= 1'b0;
            rx_accept_o <= 1'b0;
        end
        else if (ce_i)
        begin
            rx_valid_o <= rx_valid_i;
            if (rx_valid_i)
                rx_accept_o <= frame_ok(rx_frame_i, rx_cfg, station_address_bytes, hash_bits);
        end
    end

    // APB handshake: one wait cycle, then pready for one cycle.
    assign apb_access = psel_i && penable_i;
    assign wr_fire = apb_access && pready_o && pwrite_i;
    assign wr_data = pwdata_i;

    // Read multiplexer and error for unmapped addresses.
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        next_err = 1'b0;
        case (paddr_i)
            CTRL_ADDR_TX_STATUS: next_rdata = {24'h000000, tx_status};
            CTRL_ADDR_RX_CFG: next_rdata = 32'h0000_0000;
            CTRL_ADDR_STATION_LO: next_rdata = station_address_bytes[31:0];
            CTRL_ADDR_STATION_HI: next_rdata = {16'h0000, station_address_bytes[47:32]};
            CTRL_ADDR_HASH_LO: next_rdata = hash_bits[31:0];
            CTRL_ADDR_HASH_HI: next_rdata = hash_bits[63:32];
            CTRL_ADDR_COLL_COUNT: next_rdata = {27'h0000000, collision_count_reg};
            CTRL_ADDR_IRQ_STATUS: next_rdata = {30'h00000000, irq_status};
            CTRL_ADDR_IRQ_MASK: next_rdata = {30'h00000000, irq_mask};
            default: next_err = 1'b1;
        endcase
    end

    // APB response registers.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
        begin
            pready_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end
        else if (ce_i)
        begin
            pready_o <= apb_access && !pready_o;
            if (apb_access && !pready_o)
            begin
                prdata_o <= pwrite_i ? 32'h0000_0000 : next_rdata;
                pslverr_o <= next_err;
            end
            else
            begin
                prdata_o <= 32'h0000_0000;
                pslverr_o <= 1'b0;
            end
        end
    end

    // Software writable configuration; bit 5 is stored but steers nothing.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
        begin
            rx_cfg <= RX_CFG_RST;
            station_address_bytes <= 48'h0000_0000_0000;
            hash_bits <= 64'h0000_0000_0000_0000;
            irq_mask <= IRQ_RST;
        end
        else if (ce_i && wr_fire)
        begin
            case (paddr_i)
                CTRL_ADDR_RX_CFG: rx_cfg <= wr_data[7:0];
                CTRL_ADDR_STATION_LO: station_address_bytes[31:0] <= wr_data;
                CTRL_ADDR_STATION_HI: station_address_bytes[47:32] <= wr_data[15:0];
                CTRL_ADDR_HASH_LO: hash_bits[31:0] <= wr_data;
                CTRL_ADDR_HASH_HI: hash_bits[63:32] <= wr_data;
                CTRL_ADDR_IRQ_MASK: irq_mask <= wr_data[1:0];
                default: ;
            endcase
        end
    end

    // Sticky interrupt status; a new event wins over a write-one clear.
    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
        begin
            irq_status <= IRQ_RST;
            irq_o <= 1'b0;
        end
        else if (ce_i)
        begin
            if (wr_fire && paddr_i == CTRL_ADDR_IRQ_STATUS)
                irq_status <= (irq_status & ~wr_data[1:0]) | {rx_valid_i, tx_end_evt};
            else
                irq_status <= irq_status | {rx_valid_i, tx_end_evt};
            irq_o <= |(irq_status & irq_mask);
        end
    end

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rstn_i);

    chk_start_clears: assert property (ce_i && tx_start_i |=> tx_status == TX_STATUS_RST)
        else $error("Transmit status not cleared at start.");
    chk_quiet_idle: assert property (
        !tx_active && !hb_wait |=> $stable(tx_status) || $past(tx_start_i))
        else $error("Transmit status changed with no transmission.");
    chk_sent_clean: assert property (
        $rose(tx_status[TS_SENT]) |-> !tx_status[TS_ABORT] && !tx_status[TS_UNDERRUN])
        else $error("Sent flag set after an abort.");
    chk_coll_flag: assert property (
        tx_status[TS_COLL] == (collision_count_reg != 5'h00))
        else $error("Collided flag disagrees with collision total.");
    chk_abort_sixteen: assert property (
        $rose(tx_status[TS_ABORT])
        |-> collision_count_reg == 5'(MAX_ATTEMPTS) && tx_abort_o && !tx_active)
        else $error("Abort not at sixteenth attempt.");
    chk_carrier_keeps: assert property (
        $rose(tx_status[TS_CARRIER_LOST])
        |-> !tx_abort_o || tx_status[TS_UNDERRUN] || tx_status[TS_ABORT])
        else $error("Carrier loss aborted the packet.");
    chk_underrun_abort: assert property (
        ce_i && underrun_now |=> tx_status[TS_UNDERRUN] && tx_abort_o && !tx_active)
        else $error("Underrun did not abort.");
    chk_hb_window: assert property (
        $rose(tx_status[TS_HB]) |-> $past(hb_cnt) == 9'(HB_LAST))
        else $error("Heartbeat flag set at wrong time.");
    chk_late_retry: assert property (
        $rose(tx_status[TS_LATE]) |-> $past(slot_done) && (tx_retry_o || tx_abort_o))
        else $error("Late collision not from a full slot.");
    chk_retry_normal: assert property (
        ce_i && coll_now && !last_attempt && !underrun_now |=> tx_retry_o && tx_active)
        else $error("Collision did not reschedule the packet.");
    // Receive filter rules, judged against the settings sampled with the frame.
    chk_err_drop: assert property (
        ce_i && rx_valid_i && rx_frame_i.crc_err && !rx_cfg[RC_KEEP_ERR]
        |=> rx_valid_o && !rx_accept_o)
        else $error("Errored frame kept with keep bit clear.");
    chk_tiny_drop: assert property (
        ce_i && rx_valid_i && rx_frame_i.len < 16'(MIN_RUNT) |=> !rx_accept_o)
        else $error("Frame under eight bytes accepted.");
    chk_short_gate: assert property (
        ce_i && rx_valid_i && rx_frame_i.len < 16'(MIN_FRAME) && !rx_cfg[RC_SHORT]
        |=> !rx_accept_o)
        else $error("Short frame accepted while disabled.");
    chk_bcast_gate: assert property (
        ce_i && rx_valid_i && (&rx_frame_i.dest) && !rx_cfg[RC_BCAST] |=> !rx_accept_o)
        else $error("Broadcast accepted while disabled.");
    chk_hash_gate: assert property (
        ce_i && rx_valid_i && rx_frame_i.dest[0] && !(&rx_frame_i.dest)
        && !(rx_cfg[RC_HASH] && hash_bits[rx_frame_i.hash_idx]) |=> !rx_accept_o)
        else $error("Group frame accepted without passing the hash.");
    chk_station_gate: assert property (
        ce_i && rx_valid_i && !rx_frame_i.dest[0] && !rx_cfg[RC_PROMISC]
        && rx_frame_i.dest != station_address_bytes |=> !rx_accept_o)
        else $error("Foreign physical frame accepted.");
    chk_classes_or: assert property (
        ce_i && rx_valid_i && !rx_frame_i.crc_err && rx_frame_i.len >= 16'(MIN_FRAME)
        && ((&rx_frame_i.dest && rx_cfg[RC_BCAST])
        || (!(&rx_frame_i.dest) && rx_frame_i.dest[0] && rx_cfg[RC_HASH]
        && hash_bits[rx_frame_i.hash_idx])
        || (!rx_frame_i.dest[0] && rx_frame_i.dest == station_address_bytes))
        |=> rx_accept_o)
        else $error("Enabled address class rejected.");
endmodule

// file: dv/medium_model.sv
`timescale 1ns/1ps
// Behavioural transmit engine and medium that raises one frame's events on request.
module medium_model (
    // Clock.
    input wire logic sys_clk_i,
    // Events towards the block.
    output logic tx_start_o,
    output logic tx_done_o,
    output logic collision_o,
    output logic fifo_empty_o,
    output logic bus_grant_o,
    output logic carrier_o,
    output logic heartbeat_o
);
    // Quiet line: no frame, FIFO fed and memory bus held.
    initial
    begin
        tx_start_o = 1'b0;
        tx_done_o = 1'b0;
        collision_o = 1'b0;
        fifo_empty_o = 1'b0;
        bus_grant_o = 1'b1;
        carrier_o = 1'b0;
        heartbeat_o = 1'b0;
    end

    // Opens a frame; carrier comes up with it.
    task start();
        @(posedge sys_clk_i);
        tx_start_o <= 1'b1;
        carrier_o <= 1'b1;
        @(posedge sys_clk_i);
        tx_start_o <= 1'b0;
    endtask

    // One collision pulse.
    task collide();
        @(posedge sys_clk_i);
        collision_o <= 1'b1;
        @(posedge sys_clk_i);
        collision_o <= 1'b0;
    endtask

    // Carrier vanishes while the frame is still going out.
    task drop_carrier();
        @(posedge sys_clk_i);
        carrier_o <= 1'b0;
    endtask

    // FIFO runs dry while the memory bus is elsewhere, then recovers.
    task underrun();
        @(posedge sys_clk_i);
        fifo_empty_o <= 1'b1;
        bus_grant_o <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        fifo_empty_o <= 1'b0;
        bus_grant_o <= 1'b1;
    endtask

    // Ends the frame; the transceiver answers with a heartbeat only if asked.
    task finish(input bit hb);
        @(posedge sys_clk_i);
        tx_done_o <= 1'b1;
        @(posedge sys_clk_i);
        tx_done_o <= 1'b0;
        carrier_o <= 1'b0;
        if (hb)
        begin
            repeat (3) @(posedge sys_clk_i);
            heartbeat_o <= 1'b1;
            repeat (6) @(posedge sys_clk_i);
            heartbeat_o <= 1'b0;
        end
    endtask
endmodule

// file: dv/testbench.sv
`timescale 1ns/1ps
module testbench
    import tx_rx_pkg::*;
;
    localparam logic [47:0] STA = 48'hA5A4A3A2A1A0;
    localparam logic [47:0] ONES = 48'hFFFFFFFFFFFF;
    localparam logic [47:0] GRP = 48'h000000000001;
    logic sys_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o, rdata;
    logic pready_o, pslverr_o, rerr;
    logic tx_start_i, tx_done_i, collision_i, fifo_empty_i, bus_grant_i, carrier_i, heartbeat_i;
    logic tx_retry_o, tx_abort_o, rx_valid_o, rx_accept_o, irq_o;
    logic rx_valid_i = 1'b0;
    rx_frame_t rx_frame_i = '0;
    int bad_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int retries = 0;
    int aborts = 0;

    // Clock at 50 MHz.
    always #10 sys_clk_i = ~sys_clk_i;

    tx_status_rx_filter_config tx_status_rx_filter_config_inst (.sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i), .ce_i(1'b1), .paddr_i(paddr_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .tx_start_i(tx_start_i), .tx_done_i(tx_done_i), .collision_i(collision_i),
        .fifo_empty_i(fifo_empty_i), .bus_grant_i(bus_grant_i), .carrier_i(carrier_i),
        .heartbeat_i(heartbeat_i), .tx_retry_o(tx_retry_o), .tx_abort_o(tx_abort_o),
        .rx_valid_i(rx_valid_i), .rx_frame_i(rx_frame_i), .rx_valid_o(rx_valid_o),
        .rx_accept_o(rx_accept_o), .irq_o(irq_o));

    medium_model medium_model_inst (.sys_clk_i(sys_clk_i), .tx_start_o(tx_start_i),
        .tx_done_o(tx_done_i), .collision_o(collision_i), .fifo_empty_o(fifo_empty_i),
        .bus_grant_o(bus_grant_i), .carrier_o(carrier_i), .heartbeat_o(heartbeat_i));

    // Counts retry and abort pulses and cuts a hung run short.
    always @(posedge sys_clk_i)
    begin
        cycles++;
        retries += (tx_retry_o === 1'b1);
        aborts += (tx_abort_o === 1'b1);
        if (cycles == 20000)
        begin
            bad_count++;
            conclude();
        end
    end

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer; read data and error are taken at the ready edge.
    task apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        int n;
        @(posedge sys_clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= addr;
        pwdata_i <= wdata;
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        n = 0;
        do
        begin
            @(posedge sys_clk_i);
            n++;
        end while (pready_o !== 1'b1);
        rdata = prdata_o;
        rerr = pslverr_o;
        check("access cycles", n, 32'h2);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task expect_tx(input string what, input logic [7:0] exp);
        apb(1'b0, CTRL_ADDR_TX_STATUS, 32'h0);
        check(what, rdata, {24'h0, exp});
    endtask

    // Programs the accept settings, presents one frame and checks the decision.
    task rx_case(input logic [7:0] cfg, input logic [47:0] dest, input logic [15:0] len,
                 input logic err, input logic [5:0] idx, input logic exp);
        apb(1'b1, CTRL_ADDR_RX_CFG, {24'h0, cfg & 8'hDF});
        @(posedge sys_clk_i);
        rx_valid_i <= 1'b1;
        rx_frame_i <= '{dest: dest, len: len, crc_err: err, hash_idx: idx};
        @(posedge sys_clk_i);
        rx_valid_i <= 1'b0;
        @(posedge sys_clk_i);
        check("rx valid", rx_valid_o, 32'h1);
        check("rx accept", rx_accept_o, {31'h0, exp});
    endtask

    task test_end(input string name);
        $display("test %s finished", name);
    endtask

    task conclude();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Main sequence.
    initial
    begin
        repeat (6) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        apb(1'b0, 8'h30, 32'h0);
        check("unmapped error", rerr, 32'h1);
        apb(1'b1, CTRL_ADDR_IRQ_MASK, 32'h1);
        medium_model_inst.start();
        expect_tx("status at start", 8'h00);
        medium_model_inst.collide();
        medium_model_inst.finish(1'b1);
        expect_tx("status collided", 8'h05);
        apb(1'b0, CTRL_ADDR_COLL_COUNT, 32'h0);
        check("collision count", rdata, 32'h1);
        check("retry pulses", retries, 32'h1);
        apb(1'b1, CTRL_ADDR_TX_STATUS, 32'h0);
        expect_tx("status after write", 8'h05);
        check("irq raised", irq_o, 32'h1);
        apb(1'b1, CTRL_ADDR_IRQ_MASK, 32'h0);
        repeat (2) @(posedge sys_clk_i);
        check("irq masked", irq_o, 32'h0);
        apb(1'b1, CTRL_ADDR_IRQ_STATUS, 32'h1);
        apb(1'b0, CTRL_ADDR_IRQ_STATUS, 32'h0);
        check("irq cleared", rdata, 32'h0);
        test_end("collision");
        medium_model_inst.start();
        expect_tx("status cleared", 8'h00);
        medium_model_inst.drop_carrier();
        repeat (5) @(posedge sys_clk_i);
        medium_model_inst.finish(1'b1);
        expect_tx("carrier lost", 8'h11);
        medium_model_inst.start();
        medium_model_inst.finish(1'b0);
        repeat (330) @(posedge sys_clk_i);
        expect_tx("heartbeat missing", 8'h41);
        medium_model_inst.start();
        repeat (2600) @(posedge sys_clk_i);
        medium_model_inst.collide();
        medium_model_inst.finish(1'b1);
        expect_tx("late collision", 8'h85);
        check("late retry", retries, 32'h2);
        test_end("medium events");
        medium_model_inst.start();
        medium_model_inst.underrun();
        expect_tx("underrun", 8'h20);
        check("underrun abort", aborts, 32'h1);
        medium_model_inst.start();
        repeat (16) medium_model_inst.collide();
        expect_tx("excess collisions", 8'h0C);
        apb(1'b0, CTRL_ADDR_COLL_COUNT, 32'h0);
        check("count at abort", rdata, 32'h10);
        check("abort pulses", aborts, 32'h2);
        check("retries before abort", retries, 32'h11);
        test_end("aborts");
        apb(1'b1, CTRL_ADDR_STATION_LO, STA[31:0]);
        apb(1'b1, CTRL_ADDR_STATION_HI, {16'h0, STA[47:32]});
        apb(1'b1, CTRL_ADDR_HASH_LO, 32'h10);
        apb(1'b1, CTRL_ADDR_HASH_HI, 32'h0);
        rx_case(8'h00, STA, 16'd64, 1'b0, 6'd0, 1'b1);
        apb(1'b0, CTRL_ADDR_RX_CFG, 32'h0);
        check("config write only", rdata, 32'h0);
        rx_case(8'h00, STA ^ 48'h100, 16'd64, 1'b0, 6'd0, 1'b0);
        rx_case(8'h10, STA ^ 48'h100, 16'd64, 1'b0, 6'd0, 1'b1);
        rx_case(8'h00, STA, 16'd64, 1'b1, 6'd0, 1'b0);
        rx_case(8'h01, STA, 16'd64, 1'b1, 6'd0, 1'b1);
        rx_case(8'h00, STA, 16'd63, 1'b0, 6'd0, 1'b0);
        rx_case(8'h02, STA, 16'd63, 1'b0, 6'd0, 1'b1);
        rx_case(8'h02, STA, 16'd8, 1'b0, 6'd0, 1'b1);
        rx_case(8'h02, STA, 16'd7, 1'b0, 6'd0, 1'b0);
        rx_case(8'h00, ONES, 16'd64, 1'b0, 6'd0, 1'b0);
        rx_case(8'h04, ONES, 16'd64, 1'b0, 6'd0, 1'b1);
        rx_case(8'h00, GRP, 16'd64, 1'b0, 6'd4, 1'b0);
        rx_case(8'h08, GRP, 16'd64, 1'b0, 6'd4, 1'b1);
        rx_case(8'h08, GRP, 16'd64, 1'b0, 6'd5, 1'b0);
        rx_case(8'h0C, ONES, 16'd64, 1'b0, 6'd0, 1'b1);
        rx_case(8'h0C, GRP, 16'd64, 1'b0, 6'd4, 1'b1);
        rx_case(8'h0C, STA, 16'd64, 1'b0, 6'd0, 1'b1);
        apb(1'b1, CTRL_ADDR_HASH_LO, 32'hFFFFFFFF);
        apb(1'b1, CTRL_ADDR_HASH_HI, 32'hFFFFFFFF);
        rx_case(8'h1C, GRP, 16'd64, 1'b0, 6'd5, 1'b1);
        rx_case(8'h1C, STA ^ 48'h100, 16'd64, 1'b0, 6'd0, 1'b1);
        test_end("receive filter");
        conclude();
    end
endmodule
